/* File: ttc_leadlag.sv */
// lead/lag shaping of the position target ahead of the pid
// assumes tick is a one-cycle strobe at the control rate
`default_nettype none
`include "ttc_params.svh"
module ttc_leadlag (
   input wire logic ref_clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic ce, // clock enable
   ttc_shape_if.filt sh // shaping link
);
   ttc_pkg::ttc_val_t prev_ff;
   logic signed [23:0] acc_ff;
   logic signed [16:0] diff;
   logic signed [25:0] leadTerm;
   logic signed [23:0] u;
   logic signed [23:0] nxt_acc;

   // lead boosts the step, lag divides the approach by a power of two
   always_comb begin
      diff = 17'(sh.setpoint) - 17'(prev_ff);
      leadTerm = (26'(diff) * 26'(signed'({1'b0, sh.leadGain}))) >>> `TTC_LEAD_FRAC;
      u = 24'(sh.setpoint) + leadTerm[23:0];
      nxt_acc = acc_ff + ((u - acc_ff) >>> sh.lagShift);
   end

   // one update per control tick
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prev_ff <= '0;
         acc_ff <= '0;
      end else if (ce && sh.tick) begin
         prev_ff <= sh.setpoint;
         acc_ff <= nxt_acc;
      end
   end

   // saturate to the output range so a big lead cannot wrap
   assign sh.shaped = (acc_ff > 24'sd32767) ? 16'sh7FFF :
                      (acc_ff < -24'sd32768) ? -16'sh8000 : acc_ff[15:0];
endmodule
`default_nettype wire

/* File: ttc_params.svh */
// constants for the throttle calibration and setpoint shaping block
// assumes a 32-bit apb register bus and a 50 mhz ref_clk
`ifndef TTC_PARAMS_SVH
`define TTC_PARAMS_SVH
// register byte offsets
`define TTC_OFF_CTRL 8'h00
`define TTC_OFF_STATUS 8'h04
`define TTC_OFF_SPAN_THR 8'h08
`define TTC_OFF_SENS1_RANGE 8'h0C
`define TTC_OFF_SENS2_RANGE 8'h10
`define TTC_OFF_TRAVEL 8'h14
`define TTC_OFF_TARGET 8'h18
`define TTC_OFF_SHAPE 8'h1C
`define TTC_OFF_GAIN_UP 8'h20
`define TTC_OFF_GAIN_LO 8'h24
`define TTC_OFF_REST_POS 8'h28
`define TTC_OFF_MAIN_RANGE 8'h2C
`define TTC_OFF_BACKUP_RANGE 8'h30
`define TTC_OFF_POSITION 8'h34
`define TTC_OFF_DRIVE 8'h38
`define TTC_OFF_INT_STATUS 8'h3C
`define TTC_OFF_INT_CLEAR 8'h40
`define TTC_OFF_INT_ENABLE 8'h44
// control bits
`define TTC_CTRL_SWAP 0
`define TTC_CTRL_CAL_RUN 1
`define TTC_CTRL_CTL_EN 2
// status bits
`define TTC_ST_DONE 0
`define TTC_ST_SPAN 1
`define TTC_ST_LIM_HI 2
`define TTC_ST_LIM_LO 3
`define TTC_ST_RAN 4
// interrupt bits: cal end, span fault, limit high, limit low
`define TTC_IRQ_W 4
// gain register fields
`define TTC_GAIN_KR 15:0
`define TTC_GAIN_TI 19:16
`define TTC_GAIN_TD 31:24
// shaping register fields
`define TTC_SHAPE_LEAD 7:0
`define TTC_SHAPE_LAG 11:8
// reset values
`define TTC_RST_SPAN_THR 16'h0100
`define TTC_RST_RANGE_POS 32'h1388_0000
`define TTC_RST_TRAVEL 32'h0064_0000
`define TTC_RST_GAIN 32'h0000_0100
// control loop timing
`define TTC_CLK_MHZ 50
`define TTC_TICK_US 100
`define TTC_TICK_CYCLES (`TTC_TICK_US * `TTC_CLK_MHZ)
// fixed point scaling
`define TTC_LEAD_FRAC 4
`define TTC_GAIN_FRAC 8
`define TTC_DIV_STEPS 34
`endif

/* File: ttc_pkg.sv */
// types shared by the throttle calibration block
// assumes values are 16-bit signed sensor or position units
`default_nettype none
package ttc_pkg;
   typedef logic signed [15:0] ttc_val_t;
   typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} ttc_div_state_t;
endpackage
`default_nettype wire

/* File: ttc_plant_model.sv */
// throttle body model: a slewing plate with two opposite sensors
// assumes the bench steers the plate in millivolts of sensor 1
`default_nettype none
module ttc_plant_model (
   input wire logic ref_clk, // clock
   input wire logic signed [15:0] plateGoal, // steered angle
   input wire logic limHiReq, // force high limit
   input wire logic limLoReq, // force low limit
   output logic signed [15:0] sensor1V, // rising sensor
   output logic signed [15:0] sensor2V, // falling sensor
   output logic limHi, // limit seeking max
   output logic limLo // limit seeking min
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [15:0] plate_ff = 16'sd0;
   // slow slew so min and max tracking sees every step, not a jump
   always_ff @(posedge ref_clk) begin
      if (plate_ff < plateGoal - 16'sd50) plate_ff <= plate_ff + 16'sd50;
      else if (plate_ff > plateGoal + 16'sd50) plate_ff <= plate_ff - 16'sd50;
      else plate_ff <= plateGoal;
   end
   // one sensor of each polarity over the 0 to 5 v span
   assign sensor1V = plate_ff;
   assign sensor2V = 16'sd5000 - plate_ff;
   assign limHi = limHiReq;
   assign limLo = limLoReq;
endmodule
`default_nettype wire

/* File: ttc_shape_if.sv */
// setpoint shaping link between the main block and its lead/lag stage
// assumes one sample per tick strobe
`default_nettype none
interface ttc_shape_if;
   ttc_pkg::ttc_val_t setpoint;
   logic [7:0] leadGain;
   logic [3:0] lagShift;
   logic tick;
   ttc_pkg::ttc_val_t shaped;
   modport ctl (output setpoint, output leadGain, output lagShift, output tick, input shaped);
   modport filt (input setpoint, input leadGain, input lagShift, input tick, output shaped);
endinterface
`default_nettype wire

/* File: ttc_throttle_cal.sv */
// throttle channel: calibration checks, sensor ranges, position, pid
// assumes an apb master, a sensor sampler and an h-bridge driver outside
//
// Overview of operation
// - at cal end, span fault if |max-min| sensor voltage below threshold
// - span fault clears the calibrated indication at that cal end
// - cal done only after a good run, never with a drive limit flag set
// - each sensor keeps min-position and max-position voltage entries
// - travel range holds min and max position in setpoint units
// - before any cal run, cal outputs equal cal inputs
// - after a cal run, cal outputs take the learned voltages
// - main and backup ranges chosen from the two inputs by swap
// - separate high and low drive limit flags during calibration
// - target passes a lead/lag stage before the pid
// - upper gain set above rest position, lower set at or below
// - zero integral time disables integral action, smaller is stronger
// - zero derivative time disables derivative action, larger stronger
// - control cal may overwrite upper gains, never lead or lag
// - swap false: input 1 main, input 2 backup; true reversed
//
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
`include "ttc_params.svh"
module ttc_throttle_cal #(
   parameter int TICK_CYCLES = `TTC_TICK_CYCLES // control rate divider
) (
   input wire logic ref_clk, // 50 mhz clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic signed [15:0] sensor1V, // analog input 1 sample
   input wire logic signed [15:0] sensor2V, // analog input 2 sample
   input wire logic driveLimitHighIn, // driver hit limit seeking max
   input wire logic driveLimitLowIn, // driver hit limit seeking min
   input wire logic ctlCalLoad, // control cal result strobe
   input wire logic [31:0] ctlCalGain, // control cal upper gain word
   output logic signed [15:0] driveCmd, // pid drive command
   output logic signed [15:0] position, // main sensor position
   output logic calDone, // calibration done
   output logic irq // level interrupt
);
   logic [2:0] ctrl_ff;
   logic [15:0] spanThr_ff;
   logic [31:0] sensRangeIn_ff [2];
   logic [31:0] travel_ff;
   ttc_pkg::ttc_val_t target_ff;
   logic [11:0] shape_ff;
   logic [31:0] gainUp_ff;
   logic [31:0] gainLo_ff;
   ttc_pkg::ttc_val_t restPos_ff;
   logic [`TTC_IRQ_W-1:0] intStat_ff;
   logic [`TTC_IRQ_W-1:0] intEn_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;
   logic wrEn;
   logic calRunPrev_ff;
   logic calRan_ff;
   logic calDone_ff;
   logic spanFault_ff;
   logic limHi_ff;
   logic limLo_ff;
   ttc_pkg::ttc_val_t minV_ff [2];
   ttc_pkg::ttc_val_t maxV_ff [2];
   logic [31:0] learned [2];
   logic [31:0] rangeOut [2];
   logic [31:0] mainRange;
   logic [31:0] backupRange;
   ttc_pkg::ttc_val_t mainV;
   logic calStart;
   logic calEnd;
   logic spanLow;
   logic [`TTC_IRQ_W-1:0] events;
   logic [31:0] rdMux;
   logic rdHit;
   logic [15:0] tickCnt_ff;
   logic tick_ff;
   ttc_pkg::ttc_div_state_t divState_ff;
   logic [5:0] divCnt_ff;
   logic [17:0] divRem_ff;
   logic [33:0] divQuo_ff;
   logic [16:0] divDen_ff;
   logic divNeg_ff;
   logic [17:0] divTrial;
   logic signed [33:0] divNum;
   logic signed [16:0] divDenS;
   logic signed [33:0] divQs;
   ttc_pkg::ttc_val_t position_ff;
   ttc_pkg::ttc_val_t drive_ff;
   logic signed [23:0] integ_ff;
   logic signed [16:0] errPrev_ff;
   logic signed [16:0] err;
   logic [31:0] gainSel;
   logic signed [25:0] dTerm;
   logic signed [25:0] pidSum;
   logic signed [47:0] pidProd;
   ttc_shape_if shapeLink ();

   // saturate a wide signed value to the 16-bit output range
   function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
      if (v > 48'sd32767) return 16'sh7FFF;
      if (v < -48'sd32768) return -16'sh8000;
      return v[15:0];
   endfunction

   // apb: ready and read data are set in the setup cycle, so access is one cycle
   assign wrEn = ce && psel && penable && pready_ff && pwrite;

   // read decode
   always_comb begin
      rdHit = 1'b1;
      rdMux = '0;
      unique case (paddr)
         `TTC_OFF_CTRL: rdMux = {29'h0, ctrl_ff};
         `TTC_OFF_STATUS: rdMux = {27'h0, calRan_ff, limLo_ff, limHi_ff, spanFault_ff,
                                   calDone_ff};
         `TTC_OFF_SPAN_THR: rdMux = {16'h0, spanThr_ff};
         `TTC_OFF_SENS1_RANGE: rdMux = sensRangeIn_ff[0];
         `TTC_OFF_SENS2_RANGE: rdMux = sensRangeIn_ff[1];
         `TTC_OFF_TRAVEL: rdMux = travel_ff;
         `TTC_OFF_TARGET: rdMux = {16'h0, target_ff};
         `TTC_OFF_SHAPE: rdMux = {20'h0, shape_ff};
         `TTC_OFF_GAIN_UP: rdMux = gainUp_ff;
         `TTC_OFF_GAIN_LO: rdMux = gainLo_ff;
         `TTC_OFF_REST_POS: rdMux = {16'h0, restPos_ff};
         `TTC_OFF_MAIN_RANGE: rdMux = mainRange;
         `TTC_OFF_BACKUP_RANGE: rdMux = backupRange;
         `TTC_OFF_POSITION: rdMux = {16'h0, position_ff};
         `TTC_OFF_DRIVE: rdMux = {16'h0, drive_ff};
         `TTC_OFF_INT_STATUS: rdMux = {28'h0, intStat_ff};
         `TTC_OFF_INT_CLEAR: rdMux = '0; // write-only
         `TTC_OFF_INT_ENABLE: rdMux = {28'h0, intEn_ff};
         default: rdHit = 1'b0;
      endcase
   end

   // apb handshake and read capture
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pready_ff <= 1'b0;
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         if (psel && !penable && !pready_ff) begin
            pready_ff <= 1'b1;
            prdata_ff <= pwrite ? 32'h0000_0000 : rdMux;
            pslverr_ff <= !rdHit;
         end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // software-written configuration; ranges are meant to change only when idle
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ctrl_ff <= '0;
         spanThr_ff <= `TTC_RST_SPAN_THR;
         sensRangeIn_ff[0] <= `TTC_RST_RANGE_POS;
         sensRangeIn_ff[1] <= `TTC_RST_RANGE_POS;
         travel_ff <= `TTC_RST_TRAVEL;
         target_ff <= '0;
         shape_ff <= '0;
         restPos_ff <= '0;
         intEn_ff <= '0;
      end else if (wrEn) begin
         unique case (paddr)
            `TTC_OFF_CTRL: ctrl_ff <= pwdata[2:0];
            `TTC_OFF_SPAN_THR: spanThr_ff <= pwdata[15:0];
            `TTC_OFF_SENS1_RANGE: sensRangeIn_ff[0] <= pwdata;
            `TTC_OFF_SENS2_RANGE: sensRangeIn_ff[1] <= pwdata;
            `TTC_OFF_TRAVEL: travel_ff <= pwdata;
            `TTC_OFF_TARGET: target_ff <= pwdata[15:0];
            `TTC_OFF_SHAPE: shape_ff <= pwdata[11:0];
            `TTC_OFF_REST_POS: restPos_ff <= pwdata[15:0];
            `TTC_OFF_INT_ENABLE: intEn_ff <= pwdata[`TTC_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // gains: control cal may replace only the upper set; lead/lag live elsewhere
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         gainUp_ff <= `TTC_RST_GAIN;
         gainLo_ff <= `TTC_RST_GAIN;
      end else if (ce) begin
         if (ctlCalLoad) begin
            gainUp_ff <= ctlCalGain;
         end else if (wrEn && paddr == `TTC_OFF_GAIN_UP) begin
            gainUp_ff <= pwdata;
         end
         if (wrEn && paddr == `TTC_OFF_GAIN_LO) begin
            gainLo_ff <= pwdata;
         end
      end
   end

   // cal run edges come from the run bit
   assign calStart = ctrl_ff[`TTC_CTRL_CAL_RUN] && !calRunPrev_ff;
   assign calEnd = !ctrl_ff[`TTC_CTRL_CAL_RUN] && calRunPrev_ff;
   // span on the main sensor; widened so the subtraction cannot wrap
   assign spanLow = (17'(maxV_ff[ctrl_ff[`TTC_CTRL_SWAP]]) -
                     17'(minV_ff[ctrl_ff[`TTC_CTRL_SWAP]])) < 17'({1'b0, spanThr_ff});

   // learn sensor extremes while a cal run is active
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         calRunPrev_ff <= 1'b0;
         minV_ff <= '{default: '0};
         maxV_ff <= '{default: '0};
      end else if (ce) begin
         calRunPrev_ff <= ctrl_ff[`TTC_CTRL_CAL_RUN];
         if (calStart) begin
            minV_ff <= '{sensor1V, sensor2V};
            maxV_ff <= '{sensor1V, sensor2V};
         end else if (ctrl_ff[`TTC_CTRL_CAL_RUN]) begin
            if (sensor1V < minV_ff[0]) minV_ff[0] <= sensor1V;
            if (sensor1V > maxV_ff[0]) maxV_ff[0] <= sensor1V;
            if (sensor2V < minV_ff[1]) minV_ff[1] <= sensor2V;
            if (sensor2V > maxV_ff[1]) maxV_ff[1] <= sensor2V;
         end
      end
   end

   // calibration flags; a limit seen during the run blocks done
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         calRan_ff <= 1'b0;
         calDone_ff <= 1'b0;
         spanFault_ff <= 1'b0;
         limHi_ff <= 1'b0;
         limLo_ff <= 1'b0;
      end else if (ce) begin
         if (calStart) begin
            calDone_ff <= 1'b0;
            spanFault_ff <= 1'b0;
            limHi_ff <= 1'b0;
            limLo_ff <= 1'b0;
         end else if (ctrl_ff[`TTC_CTRL_CAL_RUN]) begin
            if (driveLimitHighIn) limHi_ff <= 1'b1;
            if (driveLimitLowIn) limLo_ff <= 1'b1;
         end else if (calEnd) begin
            calRan_ff <= 1'b1;
            spanFault_ff <= spanLow;
            calDone_ff <= !spanLow && !limHi_ff && !limLo_ff;
         end
      end
   end

   // cal outputs: inputs until a run, then learned, keeping input polarity
   for (genvar s = 0; s < 2; s++) begin : g_range
      assign learned[s] = ($signed(sensRangeIn_ff[s][15:0]) <= $signed(sensRangeIn_ff[s][31:16]))
                          ? {maxV_ff[s], minV_ff[s]} : {minV_ff[s], maxV_ff[s]};
      assign rangeOut[s] = calRan_ff ? learned[s] : sensRangeIn_ff[s];
   end
   assign mainRange = rangeOut[ctrl_ff[`TTC_CTRL_SWAP]];
   assign backupRange = rangeOut[!ctrl_ff[`TTC_CTRL_SWAP]];
   assign mainV = ctrl_ff[`TTC_CTRL_SWAP] ? sensor2V : sensor1V;

   // control tick divider
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tickCnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (ce) begin
         tick_ff <= (tickCnt_ff == 16'(TICK_CYCLES - 1));
         tickCnt_ff <= (tickCnt_ff == 16'(TICK_CYCLES - 1)) ? '0 : tickCnt_ff + 16'h0001;
      end
   end

   // interpolation operands: (v - v0) * (t1 - t0) / (v1 - v0)
   assign divNum = 34'(17'(mainV) - 17'($signed(mainRange[15:0]))) *
                   34'(17'($signed(travel_ff[31:16])) - 17'($signed(travel_ff[15:0])));
   assign divDenS = 17'($signed(mainRange[31:16])) - 17'($signed(mainRange[15:0]));
   assign divTrial = {divRem_ff[16:0], divQuo_ff[33]};
   assign divQs = divNeg_ff ? -$signed(divQuo_ff) : $signed(divQuo_ff);

   // serial divider; a flat range leaves the old position in place
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         divState_ff <= ttc_pkg::DIV_IDLE;
         divCnt_ff <= '0;
         divRem_ff <= '0;
         divQuo_ff <= '0;
         divDen_ff <= '0;
         divNeg_ff <= 1'b0;
         position_ff <= '0;
      end else if (ce) begin
         unique case (divState_ff)
            ttc_pkg::DIV_IDLE: if (divDenS != 17'sd0) begin
               divState_ff <= ttc_pkg::DIV_RUN;
               divCnt_ff <= 6'(`TTC_DIV_STEPS);
               divRem_ff <= '0;
               divQuo_ff <= divNum[33] ? 34'(-divNum) : divNum;
               divDen_ff <= divDenS[16] ? 17'(-divDenS) : divDenS;
               divNeg_ff <= divNum[33] ^ divDenS[16];
            end
            ttc_pkg::DIV_RUN: begin
               if (divTrial >= {1'b0, divDen_ff}) begin
                  divRem_ff <= divTrial - {1'b0, divDen_ff};
                  divQuo_ff <= {divQuo_ff[32:0], 1'b1};
               end else begin
                  divRem_ff <= divTrial;
                  divQuo_ff <= {divQuo_ff[32:0], 1'b0};
               end
               divCnt_ff <= divCnt_ff - 6'h01;
               if (divCnt_ff == 6'h01) divState_ff <= ttc_pkg::DIV_IDLE;
            end
         endcase
         // a zero quotient is a valid position; only the untouched reset state is skipped
         if (divState_ff == ttc_pkg::DIV_IDLE && divCnt_ff == 6'h00 && divDen_ff != '0) begin
            position_ff <= sat16(48'(divQs) + 48'($signed(travel_ff[15:0])));
         end
      end
   end

   // shaping link
   assign shapeLink.setpoint = target_ff;
   assign shapeLink.leadGain = shape_ff[`TTC_SHAPE_LEAD];
   assign shapeLink.lagShift = shape_ff[`TTC_SHAPE_LAG];
   assign shapeLink.tick = tick_ff;

   ttc_leadlag u_leadlag (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .sh(shapeLink)
   );

   // pid terms; gain set picked against the raw target
   assign gainSel = (target_ff > restPos_ff) ? gainUp_ff : gainLo_ff;
   assign err = 17'(shapeLink.shaped) - 17'(position_ff);
   assign dTerm = 26'(err - errPrev_ff) * 26'(signed'({1'b0, gainSel[`TTC_GAIN_TD]}));
   assign pidSum = 26'(err) + 26'(integ_ff) + dTerm;
   assign pidProd = 48'(pidSum) * 48'($signed(gainSel[`TTC_GAIN_KR]));

   // pid update; integral shift of zero disables, bigger shift is weaker
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         integ_ff <= '0;
         errPrev_ff <= '0;
         drive_ff <= '0;
      end else if (ce) begin
         if (!ctrl_ff[`TTC_CTRL_CTL_EN] || ctrl_ff[`TTC_CTRL_CAL_RUN]) begin
            integ_ff <= '0;
            errPrev_ff <= '0;
            drive_ff <= '0;
         end else if (tick_ff) begin
            errPrev_ff <= err;
            integ_ff <= (gainSel[`TTC_GAIN_TI] == 4'h0) ? '0 :
                        integ_ff + (24'(err) >>> gainSel[`TTC_GAIN_TI]);
            drive_ff <= sat16(pidProd >>> `TTC_GAIN_FRAC);
         end
      end
   end

   // sticky events; a set in the same cycle as a clear wins
   assign events = {calEnd && limLo_ff, calEnd && limHi_ff, calEnd && spanLow, calEnd};
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         intStat_ff <= '0;
         irq_ff <= 1'b0;
      end else if (ce) begin
         intStat_ff <= (intStat_ff & ~((wrEn && paddr == `TTC_OFF_INT_CLEAR) ?
                       pwdata[`TTC_IRQ_W-1:0] : '0)) | events;
         irq_ff <= |(intStat_ff & intEn_ff);
      end
   end

   // outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign driveCmd = drive_ff;
   assign position = position_ff;
   assign calDone = calDone_ff;
   assign irq = irq_ff;
endmodule
`default_nettype wire

/* File: ttc_throttle_cal_asserts.sv */
// port checker for the throttle channel, bound to its top module
// assumes one ref_clk domain and apb writes as the only way to set bits
`default_nettype none
`include "ttc_params.svh"
module ttc_throttle_cal_asserts (
   input wire logic ref_clk, // clock
   input wire logic rst_b, // reset
   input wire logic ce, // enable
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic [7:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic driveLimitHighIn, // high limit
   input wire logic driveLimitLowIn, // low limit
   input wire logic calDone, // cal done
   input wire logic irq // interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic calRun_ff, everRun_ff, limSeen_ff, wrAcc, runWr;
   logic [`TTC_IRQ_W-1:0] irqEn_ff;
   assign wrAcc = psel && penable && pready && pwrite;
   assign runWr = wrAcc && paddr == `TTC_OFF_CTRL;
   // mirrors of run bit and irq enables; a limit in a run blocks done until the next run
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         calRun_ff <= 1'b0;
         irqEn_ff <= '0;
         limSeen_ff <= 1'b0;
         everRun_ff <= 1'b0;
      end else begin
         if (runWr) calRun_ff <= pwdata[`TTC_CTRL_CAL_RUN];
         if (wrAcc && paddr == `TTC_OFF_INT_ENABLE) irqEn_ff <= pwdata[`TTC_IRQ_W-1:0];
         if (calRun_ff) everRun_ff <= 1'b1;
         if (runWr && pwdata[`TTC_CTRL_CAL_RUN] && !calRun_ff) limSeen_ff <= 1'b0;
         else if (calRun_ff && (driveLimitHighIn || driveLimitLowIn)) limSeen_ff <= 1'b1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   setup_ready_a: assert property (psel && !penable && ce |=> pready)
      else $error("setup not answered");
   ready_cause_a: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   unmapped_err_a: assert property (psel && !penable && ce |=>
                                    pslverr == ($past(paddr) > `TTC_OFF_INT_ENABLE))
      else $error("error flag wrong");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   irq_enable_a: assert property (irq |-> $past(irqEn_ff) != '0)
      else $error("irq while masked");
   done_nolimit_a: assert property (limSeen_ff |-> !calDone)
      else $error("done with limit");
   done_needs_run_a: assert property (!everRun_ff |-> !calDone)
      else $error("done before any run");
   done_clear_a: assert property ($rose(calRun_ff) |-> ##[1:3] !calDone)
      else $error("done kept at run start");
   run_end_c: cover property ($fell(calRun_ff) ##2 calDone);
   irq_c: cover property (irq);
   slverr_c: cover property (pslverr);
endmodule
bind ttc_throttle_cal ttc_throttle_cal_asserts chk (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .driveLimitHighIn(driveLimitHighIn),
   .driveLimitLowIn(driveLimitLowIn), .calDone(calDone), .irq(irq));
`default_nettype wire

/* File: ttc_throttle_cal_test.sv */
// self-checking bench for the throttle calibration block
// assumes the plate model beside it; tick shortened to 8 cycles
`default_nettype none
module ttc_throttle_cal_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = '0, rst_b = '0, psel = '0, penable = '0, pwrite = '0;
   logic ctlCalLoad = '0, limHiReq = '0, limLoReq = '0, lastErr;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, ctlCalGain = '0, prdata, q;
   logic pready, pslverr, calDone, irq, limHi, limLo;
   logic signed [15:0] sensor1V, sensor2V, driveCmd, position, rp;
   logic signed [15:0] plateGoal = 16'sd1000;
   int errCount = 0, nTests = 0;
   // 50 mhz clock
   always #10 ref_clk = ~ref_clk;
   ttc_throttle_cal #(.TICK_CYCLES(8)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sensor1V(sensor1V),
      .sensor2V(sensor2V), .driveLimitHighIn(limHi), .driveLimitLowIn(limLo),
      .ctlCalLoad(ctlCalLoad), .ctlCalGain(ctlCalGain), .driveCmd(driveCmd),
      .position(position), .calDone(calDone), .irq(irq));
   ttc_plant_model plant (.ref_clk(ref_clk), .plateGoal(plateGoal), .limHiReq(limHiReq),
      .limLoReq(limLoReq), .sensor1V(sensor1V), .sensor2V(sensor2V), .limHi(limHi),
      .limLo(limLo));
   task automatic printVerdict();
      $display("errors %0d checks %0d", errCount, nTests);
      if (errCount == 0 && nTests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one transfer; the request holds until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errCount++;
         printVerdict();
      end
      q = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(q, exp);
   endtask
   // one position run from 1000 mv up to hi, with optional limit hits
   task automatic calRun(input logic signed [15:0] hi, input logic lh, input logic ll,
      input logic [31:0] st);
      plateGoal <= 16'sd1000;
      repeat (80) @(posedge ref_clk);
      apb(1'b1, 8'h00, 32'h0000_0002);
      plateGoal <= hi;
      repeat (80) @(posedge ref_clk);
      limHiReq <= lh;
      limLoReq <= ll;
      @(posedge ref_clk);
      limHiReq <= 1'b0;
      limLoReq <= 1'b0;
      apb(1'b1, 8'h00, 32'h0000_0000);
      plateGoal <= 16'sd2500;
      repeat (4) @(posedge ref_clk);
      rd(8'h04, st);
      chk(32'(calDone), 32'(st[0]));
   endtask
   task automatic tReset();
      rd(8'h08, 32'h0000_0100);
      rd(8'h0C, 32'h1388_0000);
      rd(8'h14, 32'h0064_0000);
      rd(8'h2C, 32'h1388_0000);
      rd(8'h48, 32'h0000_0000);
      chk(32'(lastErr), 32'h0000_0001);
   endtask
   task automatic tSwap();
      apb(1'b1, 8'h10, 32'h0000_1388);
      rd(8'h30, 32'h0000_1388);
      apb(1'b1, 8'h00, 32'h0000_0001);
      rd(8'h2C, 32'h0000_1388);
      rd(8'h30, 32'h1388_0000);
      apb(1'b1, 8'h00, 32'h0000_0000);
   endtask
   // good run, then raise, mask and clear the cal-end interrupt
   task automatic tCalGood();
      apb(1'b1, 8'h40, 32'h0000_000F);
      apb(1'b1, 8'h44, 32'h0000_0001);
      calRun(16'sd4000, 1'b0, 1'b0, 32'h0000_0011);
      rd(8'h2C, 32'h0FA0_03E8);
      repeat (80) @(posedge ref_clk);
      chk({16'h0000, position}, 32'h0000_0032);
      chk(32'(irq), 32'h0000_0001);
      rd(8'h3C, 32'h0000_0001);
      apb(1'b1, 8'h44, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, 8'h44, 32'h0000_0001);
      apb(1'b1, 8'h40, 32'h0000_000F);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000);
   endtask
   // upper set zeroed by a control cal, lower set left at unity
   task automatic tGain();
      apb(1'b1, 8'h1C, 32'h0000_0110);
      ctlCalLoad <= 1'b1;
      @(posedge ref_clk);
      ctlCalLoad <= 1'b0;
      rd(8'h20, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0110);
      apb(1'b0, 8'h28, 32'h0000_0000);
      rp = q[15:0];
      apb(1'b1, 8'h18, {16'h0000, rp + 16'sd1});
      apb(1'b1, 8'h00, 32'h0000_0004);
      repeat (200) @(posedge ref_clk);
      chk({16'h0000, driveCmd}, 32'h0000_0000);
      apb(1'b1, 8'h18, {16'h0000, rp});
      repeat (200) @(posedge ref_clk);
      chk(32'(driveCmd[15]), 32'(rp < 16'sd50));
      apb(1'b1, 8'h00, 32'h0000_0000);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      tReset();
      tSwap();
      calRun(16'sd1100, 1'b0, 1'b0, 32'h0000_0012);
      tCalGood();
      calRun(16'sd4000, 1'b1, 1'b0, 32'h0000_0014);
      calRun(16'sd4000, 1'b0, 1'b1, 32'h0000_0018);
      tGain();
      printVerdict();
   end
endmodule
`default_nettype wire
